/* File: src/cfg_map.svh */
// Register indices, field positions, reset values and limits for the input and feedback configuration bank.
// Assumes byte address = 4 x index on a 32-bit AXI4-Lite bus; data sits in the low 16 bits.
// Function
// - Bits 5..2 hold oscillator bias tune, reset 5h; code 0h switches bias off.
// - Bits 11..14 enable the bypass buffer of channels one to four; reset cleared.
// - Bit 10 lets the input clock onto the reference copy output.
// - Bit 9 picks reference copy source: 0h reference clock, 1h phase detector clock.
// - Bit 8 holds reference divider in reset; reset also active during any reset.
// - Eight-bit reference ratio: 0 turns the doubler on, 1..255 divide by code.
// - Bits 15..14 pick feedback pre-scaler /4, /5, /6 for codes 0h, 1h, 2h.
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH

`define IDX_CRYSTAL_INPUT 10'h01A
`define IDX_BYPASS_REFDIV 10'h01B
`define IDX_DEBUG_SPARE 10'h01C
`define IDX_FEEDBACK_DIV 10'h01D
`define IDX_STATUS 10'h030

`define RST_CRYSTAL_INPUT 16'hB14
`define RST_BYPASS_REFDIV 16'h0000
`define RST_DEBUG_SPARE 16'h0000
`define RST_FEEDBACK_DIV 16'h000C

`define F_INBUF_MSB 1
`define F_INBUF_LSB 0
`define F_BIAS_MSB 5
`define F_BIAS_LSB 2
`define F_CLOAD_MSB 12
`define F_CLOAD_LSB 8
`define F_REFBUF_BIT 15
`define F_RATIO_MSB 7
`define F_RATIO_LSB 0
`define F_RDIV_RST_BIT 8
`define F_COPY_SRC_BIT 9
`define F_COPY_EN_BIT 10
`define F_BYP_LSB 11
`define F_BYP_MSB 14
`define F_NDIV_MSB 13
`define F_NDIV_LSB 0
`define F_PSFB_MSB 15
`define F_PSFB_LSB 14

`define BIAS_OFF 4'h0
`define INBUF_XO 2'h0
`define INBUF_CMOS 2'h1
`define INBUF_DIFF 2'h2
`define RATIO_DOUBLER 8'h00
`define PSFB_DIV4 2'h0
`define PSFB_DIV5 2'h1
`define PSFB_DIV6 2'h2
`define NDIV_MIN 14'h0006

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/cfg_pkg.sv */
// Types shared by the configuration bank, its bus front end and the register access carrier.
// Assumes the map header supplies every number.
package cfg_pkg;
  typedef logic [9:0] reg_index_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;
  typedef enum logic [2:0] {RD_IDLE = 3'b001, RD_LOOKUP = 3'b010, RD_RESP = 3'b100} rd_state_e;
endpackage

/* File: src/reg_access_if.sv */
// Carrier between the AXI4-Lite front end and the register bank.
// Assumes both ends run on aclk; wr_en is a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  import cfg_pkg::*;
  logic wr_en;
  reg_index_t wr_index;
  reg_word_t wdata;
  logic [1:0] wstrb;
  logic wr_hit;
  reg_index_t rd_index;
  reg_word_t rdata;
  logic rd_hit;
  modport front (output wr_en, output wr_index, output wdata, output wstrb, output rd_index,
                 input wr_hit, input rdata, input rd_hit);
  modport regs (input wr_en, input wr_index, input wdata, input wstrb, input rd_index,
                output wr_hit, output rdata, output rd_hit);
endinterface
`default_nettype wire

/* File: src/sync3.sv */
// Three-stage synchroniser for pin inputs; the output follows once stages two and three agree.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sync3 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign level_out = out_ff;
endmodule
`default_nettype wire

/* File: src/axil_front.sv */
// AXI4-Lite slave front end: takes one write and one read at a time and hands them to the bank.
// Assumes the bank answers hit and read data combinationally from the presented index.
`timescale 1ns/100ps
`default_nettype none
module axil_front
  import cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_access_if.front bus
);
  `include "cfg_map.svh"

  wr_state_e wst_ff, nxt_wst;
  rd_state_e rst_ff, nxt_rst;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  reg_index_t waddr_ff, nxt_waddr, raddr_ff, nxt_raddr;
  reg_word_t wdat_ff, nxt_wdat;
  logic [1:0] wstb_ff, nxt_wstb;
  logic [31:0] rdata_ff, nxt_rdata;
  logic do_write;

  // Both halves of a write are held once their ready has dropped.
  assign do_write = (wst_ff == WR_IDLE) && !awready_ff && !wready_ff;

  always_comb begin
    nxt_wst = wst_ff;
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_waddr = waddr_ff;
    nxt_wdat = wdat_ff;
    nxt_wstb = wstb_ff;
    unique case (wst_ff)
      WR_IDLE: begin
        if (awvalid && awready_ff) begin
          nxt_awready = 1'b0;
          nxt_waddr = awaddr[11:2];
        end
        if (wvalid && wready_ff) begin
          nxt_wready = 1'b0;
          nxt_wdat = wdata[15:0];
          nxt_wstb = wstrb[1:0];
        end
        if (do_write) begin
          nxt_bvalid = 1'b1;
          nxt_bresp = bus.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
          nxt_wst = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_bvalid = 1'b0;
          nxt_awready = 1'b1;
          nxt_wready = 1'b1;
          nxt_wst = WR_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    nxt_rst = rst_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_raddr = raddr_ff;
    nxt_rdata = rdata_ff;
    unique case (rst_ff)
      RD_IDLE: begin
        if (arvalid) begin
          nxt_arready = 1'b0;
          nxt_raddr = araddr[11:2];
          nxt_rst = RD_LOOKUP;
        end
      end
      RD_LOOKUP: begin
        nxt_rdata = {16'h0000, bus.rdata};
        nxt_rresp = bus.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        nxt_rvalid = 1'b1;
        nxt_rst = RD_RESP;
      end
      RD_RESP: begin
        if (rready) begin
          nxt_rvalid = 1'b0;
          nxt_arready = 1'b1;
          nxt_rst = RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_ff <= WR_IDLE;
      rst_ff <= RD_IDLE;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      waddr_ff <= 10'h000;
      raddr_ff <= 10'h000;
      wdat_ff <= 16'h0000;
      wstb_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      wst_ff <= nxt_wst;
      rst_ff <= nxt_rst;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      waddr_ff <= nxt_waddr;
      raddr_ff <= nxt_raddr;
      wdat_ff <= nxt_wdat;
      wstb_ff <= nxt_wstb;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus.wr_en = do_write;
  assign bus.wr_index = waddr_ff;
  assign bus.wdata = wdat_ff;
  assign bus.wstrb = wstb_ff;
  assign bus.rd_index = raddr_ff;
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

/* File: src/input_feedback_cfg.sv */
// Input stage and feedback path configuration bank with an AXI4-Lite slave port.
// Assumes one clock aclk; software_reset arrives from outside the clock domain.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module input_feedback_cfg
  import cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic software_reset,
  output logic [3:0] oscillator_bias_tune,
  output logic oscillator_bias_on,
  output logic crystal_oscillator_select,
  output logic cmos_buffer_select,
  output logic diff_buffer_select,
  output logic ref_input_diff_select,
  output logic [4:0] crystal_load_cap,
  output logic bypass_buffer_enable_first,
  output logic bypass_buffer_enable_second,
  output logic bypass_buffer_enable_third,
  output logic bypass_buffer_enable_fourth,
  output logic reference_copy_from_ref,
  output logic reference_copy_from_pfd,
  output logic ref_divider_reset,
  output logic [7:0] ref_divider_ratio,
  output logic ref_doubler_enable,
  output logic [2:0] feedback_prescale_ratio,
  output logic [13:0] feedback_divider,
  output logic feedback_divider_low
);
  `include "cfg_map.svh"

  reg_access_if bus ();

  reg_word_t crystal_ff, nxt_crystal;
  reg_word_t bypass_ff, nxt_bypass;
  reg_word_t debug_ff, nxt_debug;
  reg_word_t feedback_ff, nxt_feedback;

  reg_word_t status_word;
  logic software_reset_level;

  logic [3:0] bias_ff, nxt_bias;
  logic bias_on_ff, nxt_bias_on;
  logic xo_sel_ff, nxt_xo_sel;
  logic cmos_sel_ff, nxt_cmos_sel;
  logic diff_sel_ff, nxt_diff_sel;

  logic refbuf_ff, nxt_refbuf;
  logic [4:0] cload_ff, nxt_cload;

  logic [3:0] byp_ff, nxt_byp;
  logic copy_ref_ff, nxt_copy_ref;
  logic copy_pfd_ff, nxt_copy_pfd;

  logic rdiv_rst_ff, nxt_rdiv_rst;
  logic [7:0] ratio_ff, nxt_ratio;
  logic doubler_ff, nxt_doubler;

  logic [2:0] psfb_ff, nxt_psfb;
  logic [13:0] ndiv_ff, nxt_ndiv;
  logic ndiv_low_ff, nxt_ndiv_low;

  axil_front u_front (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(bus.front)
  );

  // The pin is asynchronous to aclk, so it is filtered first.
  sync3 #(.W(1)) u_software_reset_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(software_reset),
    .level_out(software_reset_level)
  );

  function automatic reg_word_t merge(input reg_word_t old_w, input reg_word_t new_w, input logic [1:0] strb);
    reg_word_t res;
    res = old_w;
    if (strb[0]) begin
      res[7:0] = new_w[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_w[15:8];
    end

    return res;
  endfunction

  function automatic logic is_mapped(input reg_index_t idx);
    return (idx == `IDX_CRYSTAL_INPUT) ||
           (idx == `IDX_BYPASS_REFDIV) ||
           (idx == `IDX_DEBUG_SPARE) ||
           (idx == `IDX_FEEDBACK_DIV) ||
           (idx == `IDX_STATUS);
  endfunction

  // Status is read-only; writes to it are accepted and dropped.
  assign status_word = {11'h000, (crystal_ff[`F_INBUF_MSB:`F_INBUF_LSB] == 2'h3), software_reset_level, rdiv_rst_ff,
                        (feedback_ff[`F_PSFB_MSB:`F_PSFB_LSB] == 2'h3), ndiv_low_ff};

  assign bus.wr_hit = is_mapped(bus.wr_index);
  assign bus.rd_hit = is_mapped(bus.rd_index);

  always_comb begin
    unique case (bus.rd_index)
      `IDX_CRYSTAL_INPUT: bus.rdata = crystal_ff;
      `IDX_BYPASS_REFDIV: bus.rdata = bypass_ff;
      `IDX_DEBUG_SPARE: bus.rdata = debug_ff;
      `IDX_FEEDBACK_DIV: bus.rdata = feedback_ff;
      `IDX_STATUS: bus.rdata = status_word;
      default: bus.rdata = 16'h0000;
    endcase
  end

  // A held software reset returns every field to its reset value.
  always_comb begin
    nxt_crystal = crystal_ff;
    nxt_bypass = bypass_ff;
    nxt_debug = debug_ff;
    nxt_feedback = feedback_ff;

    if (software_reset_level) begin
      nxt_crystal = `RST_CRYSTAL_INPUT;
      nxt_bypass = `RST_BYPASS_REFDIV;
      nxt_debug = `RST_DEBUG_SPARE;
      nxt_feedback = `RST_FEEDBACK_DIV;
    end else if (bus.wr_en) begin
      if (bus.wr_index == `IDX_CRYSTAL_INPUT) begin
        nxt_crystal = merge(crystal_ff, bus.wdata, bus.wstrb);
      end
      if (bus.wr_index == `IDX_BYPASS_REFDIV) begin
        nxt_bypass = merge(bypass_ff, bus.wdata, bus.wstrb);
      end
      if (bus.wr_index == `IDX_DEBUG_SPARE) begin
        nxt_debug = merge(debug_ff, bus.wdata, bus.wstrb);
      end
      if (bus.wr_index == `IDX_FEEDBACK_DIV) begin
        nxt_feedback = merge(feedback_ff, bus.wdata, bus.wstrb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_ff <= `RST_CRYSTAL_INPUT;
      bypass_ff <= `RST_BYPASS_REFDIV;
      debug_ff <= `RST_DEBUG_SPARE;
      feedback_ff <= `RST_FEEDBACK_DIV;
    end else begin
      crystal_ff <= nxt_crystal;
      bypass_ff <= nxt_bypass;
      debug_ff <= nxt_debug;
      feedback_ff <= nxt_feedback;
    end
  end

  // Outputs are registered once more so each pin leaves a flip-flop.
  always_comb begin
    nxt_bias = crystal_ff[`F_BIAS_MSB:`F_BIAS_LSB];
    nxt_bias_on = (crystal_ff[`F_BIAS_MSB:`F_BIAS_LSB] != `BIAS_OFF);

    nxt_xo_sel = (crystal_ff[`F_INBUF_MSB:`F_INBUF_LSB] == `INBUF_XO);
    nxt_cmos_sel = (crystal_ff[`F_INBUF_MSB:`F_INBUF_LSB] == `INBUF_CMOS);
    nxt_diff_sel = (crystal_ff[`F_INBUF_MSB:`F_INBUF_LSB] == `INBUF_DIFF);

    nxt_refbuf = crystal_ff[`F_REFBUF_BIT];
    nxt_cload = crystal_ff[`F_CLOAD_MSB:`F_CLOAD_LSB];

    nxt_byp = bypass_ff[`F_BYP_MSB:`F_BYP_LSB];

    nxt_copy_ref = bypass_ff[`F_COPY_EN_BIT] && !bypass_ff[`F_COPY_SRC_BIT];
    nxt_copy_pfd = bypass_ff[`F_COPY_EN_BIT] && bypass_ff[`F_COPY_SRC_BIT];

    nxt_rdiv_rst = bypass_ff[`F_RDIV_RST_BIT] || software_reset_level;

    nxt_ratio = bypass_ff[`F_RATIO_MSB:`F_RATIO_LSB];
    nxt_doubler = (bypass_ff[`F_RATIO_MSB:`F_RATIO_LSB] == `RATIO_DOUBLER);

    unique case (feedback_ff[`F_PSFB_MSB:`F_PSFB_LSB])
      `PSFB_DIV4: nxt_psfb = 3'h4;
      `PSFB_DIV5: nxt_psfb = 3'h5;
      default: nxt_psfb = 3'h6;
    endcase

    nxt_ndiv = feedback_ff[`F_NDIV_MSB:`F_NDIV_LSB];
    nxt_ndiv_low = (feedback_ff[`F_NDIV_MSB:`F_NDIV_LSB] < `NDIV_MIN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_ff <= 4'h5;
      bias_on_ff <= 1'b1;
      xo_sel_ff <= 1'b1;
      cmos_sel_ff <= 1'b0;
      diff_sel_ff <= 1'b0;
      refbuf_ff <= 1'b0;
      cload_ff <= 5'h0B;

      byp_ff <= 4'h0;
      copy_ref_ff <= 1'b0;
      copy_pfd_ff <= 1'b0;

      rdiv_rst_ff <= 1'b1;
      ratio_ff <= 8'h00;
      doubler_ff <= 1'b1;
      psfb_ff <= 3'h4;
      ndiv_ff <= 14'h000C;
      ndiv_low_ff <= 1'b0;
    end else begin
      bias_ff <= nxt_bias;
      bias_on_ff <= nxt_bias_on;
      xo_sel_ff <= nxt_xo_sel;
      cmos_sel_ff <= nxt_cmos_sel;
      diff_sel_ff <= nxt_diff_sel;
      refbuf_ff <= nxt_refbuf;
      cload_ff <= nxt_cload;

      byp_ff <= nxt_byp;
      copy_ref_ff <= nxt_copy_ref;
      copy_pfd_ff <= nxt_copy_pfd;

      rdiv_rst_ff <= nxt_rdiv_rst;
      ratio_ff <= nxt_ratio;
      doubler_ff <= nxt_doubler;
      psfb_ff <= nxt_psfb;
      ndiv_ff <= nxt_ndiv;
      ndiv_low_ff <= nxt_ndiv_low;
    end
  end

  assign oscillator_bias_tune = bias_ff;
  assign oscillator_bias_on = bias_on_ff;

  assign crystal_oscillator_select = xo_sel_ff;
  assign cmos_buffer_select = cmos_sel_ff;
  assign diff_buffer_select = diff_sel_ff;

  assign ref_input_diff_select = refbuf_ff;
  assign crystal_load_cap = cload_ff;

  assign bypass_buffer_enable_first = byp_ff[0];
  assign bypass_buffer_enable_second = byp_ff[1];
  assign bypass_buffer_enable_third = byp_ff[2];
  assign bypass_buffer_enable_fourth = byp_ff[3];

  assign reference_copy_from_ref = copy_ref_ff;
  assign reference_copy_from_pfd = copy_pfd_ff;

  assign ref_divider_reset = rdiv_rst_ff;
  assign ref_divider_ratio = ratio_ff;
  assign ref_doubler_enable = doubler_ff;

  assign feedback_prescale_ratio = psfb_ff;
  assign feedback_divider = ndiv_ff;
  assign feedback_divider_low = ndiv_low_ff;
endmodule
`default_nettype wire

/* File: testbench/input_feedback_cfg_chk.sv */
// Concurrent checks on the ports of the input and feedback configuration bank.
// Assumes it is bound to input_feedback_cfg and that everything runs on aclk.
`timescale 1ns/100ps
`default_nettype none
module input_feedback_cfg_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic software_reset,
  input wire logic [3:0] oscillator_bias_tune,
  input wire logic oscillator_bias_on,
  input wire logic reference_copy_from_ref,
  input wire logic reference_copy_from_pfd,
  input wire logic ref_divider_reset,
  input wire logic [7:0] ref_divider_ratio,
  input wire logic ref_doubler_enable,
  input wire logic [2:0] feedback_prescale_ratio,
  input wire logic [13:0] feedback_divider,
  input wire logic feedback_divider_low
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    !s_axi_rvalid ##[1:2] s_axi_rvalid;
  endsequence
  bias_on_a: assert property (oscillator_bias_on == (oscillator_bias_tune != 4'h0))
    else $error("bias enable does not follow the tune code");
  copy_src_a: assert property (!(reference_copy_from_ref && reference_copy_from_pfd))
    else $error("reference copy driven from both sources");
  doubler_code_a: assert property (ref_doubler_enable == (ref_divider_ratio == 8'h00))
    else $error("doubler enable does not match ratio code");
  prescale_range_a: assert property (feedback_prescale_ratio inside {3'h4, 3'h5, 3'h6})
    else $error("prescale ratio outside four to six");
  div_low_a: assert property (feedback_divider_low == (feedback_divider < 14'h0006))
    else $error("low divider flag wrong");
  sw_reset_a: assert property (software_reset [*6] |-> ref_divider_reset)
    else $error("divider reset not held during software reset");
  wr_resp_a: assert property (wr_take |=> !s_axi_awready ##[0:2] s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_take |=> rd_answer)
    else $error("read answer timing wrong");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule

bind input_feedback_cfg input_feedback_cfg_chk input_feedback_cfg_chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .software_reset,
  .oscillator_bias_tune, .oscillator_bias_on, .reference_copy_from_ref, .reference_copy_from_pfd,
  .ref_divider_reset, .ref_divider_ratio, .ref_doubler_enable, .feedback_prescale_ratio,
  .feedback_divider, .feedback_divider_low
);
`default_nettype wire

/* File: testbench/input_feedback_cfg_test.sv */
// Self-checking bench for the configuration bank, driven over AXI4-Lite.
// Assumes the register map header and a 25 MHz clock; expectations come from a shadow model.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_map.svh"
module input_feedback_cfg_test;
  import cfg_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic software_reset, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, oscillator_bias_tune;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic oscillator_bias_on, crystal_oscillator_select, cmos_buffer_select, diff_buffer_select;
  logic ref_input_diff_select, bypass_buffer_enable_first, bypass_buffer_enable_second;
  logic bypass_buffer_enable_third, bypass_buffer_enable_fourth, reference_copy_from_ref;
  logic reference_copy_from_pfd, ref_divider_reset, ref_doubler_enable, feedback_divider_low;
  logic [4:0] crystal_load_cap;
  logic [7:0] ref_divider_ratio;
  logic [2:0] feedback_prescale_ratio;
  logic [13:0] feedback_divider;
  logic [15:0] mdl [`IDX_CRYSTAL_INPUT:`IDX_FEEDBACK_DIV];
  logic [25:0] corners [8];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [9:0] ridx;

  input_feedback_cfg input_feedback_cfg_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .software_reset, .oscillator_bias_tune, .oscillator_bias_on, .crystal_oscillator_select,
    .cmos_buffer_select, .diff_buffer_select, .ref_input_diff_select, .crystal_load_cap,
    .bypass_buffer_enable_first, .bypass_buffer_enable_second, .bypass_buffer_enable_third,
    .bypass_buffer_enable_fourth, .reference_copy_from_ref, .reference_copy_from_pfd,
    .ref_divider_reset, .ref_divider_ratio, .ref_doubler_enable, .feedback_prescale_ratio,
    .feedback_divider, .feedback_divider_low
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the several hundred cycles the sequence needs.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [2:0] psr(input logic [1:0] code);
    return (code == `PSFB_DIV4) ? 3'h4 : (code == `PSFB_DIV5) ? 3'h5 : 3'h6;
  endfunction

  task automatic reset_model();
    mdl[`IDX_CRYSTAL_INPUT] = `RST_CRYSTAL_INPUT;
    mdl[`IDX_BYPASS_REFDIV] = `RST_BYPASS_REFDIV;
    mdl[`IDX_DEBUG_SPARE] = `RST_DEBUG_SPARE;
    mdl[`IDX_FEEDBACK_DIV] = `RST_FEEDBACK_DIV;
  endtask

  task automatic axi_write(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] st,
                           input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'($urandom), d};
    s_axi_wstrb <= {2'($urandom), st};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
    if (idx >= `IDX_CRYSTAL_INPUT && idx <= `IDX_FEEDBACK_DIV) begin
      for (int b = 0; b < 2; b++) begin
        if (st[b]) mdl[idx][8*b+:8] = d[8*b+:8];
      end
    end
  endtask

  task automatic axi_read(input logic [9:0] idx);
    s_axi_araddr <= {idx, 2'($urandom)};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  // Reads every register back and compares all decoded outputs with the shadow model.
  task automatic verify_all();
    logic [15:0] cr;
    logic [15:0] bp;
    logic [15:0] fb;
    for (int i = `IDX_CRYSTAL_INPUT; i <= `IDX_FEEDBACK_DIV; i++) begin
      axi_read(10'(i));
      check(rr, `RESP_OKAY);
      check(rd, {16'h0000, mdl[i]});
    end
    cr = mdl[`IDX_CRYSTAL_INPUT];
    bp = mdl[`IDX_BYPASS_REFDIV];
    fb = mdl[`IDX_FEEDBACK_DIV];
    check(oscillator_bias_tune, cr[5:2]);
    check(oscillator_bias_on, cr[5:2] != `BIAS_OFF);
    check({crystal_oscillator_select, cmos_buffer_select, diff_buffer_select},
          {cr[1:0] == `INBUF_XO, cr[1:0] == `INBUF_CMOS, cr[1:0] == `INBUF_DIFF});
    check({ref_input_diff_select, crystal_load_cap}, {cr[15], cr[12:8]});
    check({bypass_buffer_enable_fourth, bypass_buffer_enable_third, bypass_buffer_enable_second,
           bypass_buffer_enable_first}, bp[14:11]);
    check(reference_copy_from_ref, bp[10] & !bp[9]);
    check(reference_copy_from_pfd, bp[10] & bp[9]);
    check(ref_divider_reset, bp[8]);
    check(ref_divider_ratio, bp[7:0]);
    check(ref_doubler_enable, bp[7:0] == `RATIO_DOUBLER);
    check(feedback_prescale_ratio, psr(fb[15:14]));
    check(feedback_divider, fb[13:0]);
    check(feedback_divider_low, fb[13:0] < `NDIV_MIN);
    axi_read(`IDX_STATUS);
    check(rr, `RESP_OKAY);
    check(rd, {27'h0000000, cr[1:0] == 2'h3, 1'b0, bp[8], fb[15:14] == 2'h3, fb[13:0] < `NDIV_MIN});
  endtask

  initial begin
    aresetn = 1'b0;
    software_reset = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0000000;
    s_axi_wdata = 32'h00000000;
    corners = '{{`IDX_CRYSTAL_INPUT, 16'h8003}, {`IDX_CRYSTAL_INPUT, 16'h1F36},
                {`IDX_BYPASS_REFDIV, 16'h00FF}, {`IDX_BYPASS_REFDIV, 16'h7E01},
                {`IDX_BYPASS_REFDIV, 16'h0500}, {`IDX_FEEDBACK_DIV, 16'hC005},
                {`IDX_FEEDBACK_DIV, 16'h8006}, {`IDX_FEEDBACK_DIV, 16'h7FFF}};
    void'($urandom(59));
    reset_model();
    repeat (10) @(posedge aclk);
    check(ref_divider_reset, 1'b1);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check(ref_divider_reset, 1'b0);
    verify_all();
    foreach (corners[i]) begin
      axi_write(corners[i][25:16], corners[i][15:0], 2'h3, `RESP_OKAY);
      verify_all();
    end
    for (int i = 0; i < 24; i++) begin
      ridx = `IDX_CRYSTAL_INPUT + 10'($urandom % 4);
      // feedback divider low byte keeps bit 6 set, so codes stay above the minimum.
      axi_write(ridx, 16'($urandom) | {9'h000, ridx == `IDX_FEEDBACK_DIV, 6'h00}, 2'($urandom), `RESP_OKAY);
      verify_all();
    end
    axi_write(10'h01E, 16'hFFFF, 2'h3, `RESP_SLVERR);
    axi_read(10'h01E);
    check(rr, `RESP_SLVERR);
    check(rd, 32'h00000000);
    axi_write(`IDX_STATUS, 16'hFFFF, 2'h3, `RESP_OKAY);
    axi_write(`IDX_BYPASS_REFDIV, 16'h1234, 2'h3, `RESP_OKAY);
    software_reset <= 1'b1;
    repeat (8) @(posedge aclk);
    check(ref_divider_reset, 1'b1);
    software_reset <= 1'b0;
    repeat (8) @(posedge aclk);
    reset_model();
    verify_all();
    conclude();
  end
endmodule
`default_nettype wire
